//--- rtl/rlts_sequencer.v
// Radio link transaction sequencer: transmit and receive sequencing
`timescale 1ns/100ps
`include "rlts_consts.vh"
module rlts_sequencer (
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    // Register port
    input  wire [3:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // Air link, receive side indications
    input  wire        i_addr_match,
    input  wire        i_pkt_done,
    input  wire        i_pkt_has_pay,
    input  wire [1:0]  i_pkt_id,
    // Air link, transmit side and receive enable
    output reg         o_tx_on,
    output reg         o_rx_on,
    output reg         o_tx_is_ack,
    output reg  [1:0]  o_tx_pkt_id,
    output reg         o_tx_pay_en,
    // Interrupt
    output wire        o_radio_interrupt
);
    // -------------------------------------------------------------------------
    // States
    // -------------------------------------------------------------------------
    localparam S_IDLE   = 3'd0;
    localparam S_SETTLE = 3'd1;
    localparam S_TX     = 3'd2;
    localparam S_ACKW   = 3'd3;
    localparam S_ACKRX  = 3'd4;
    localparam S_DELAY  = 3'd5;
    localparam S_PRX    = 3'd6;
    localparam S_PRXACK = 3'd7;

    // -------------------------------------------------------------------------
    // Link input synchroniser
    // -------------------------------------------------------------------------
    wire [4:0] lnk_s;
    wire       lnk_match;
    wire       lnk_done;
    wire       lnk_pay;
    wire [1:0] lnk_id;
    reg        match_d_r;
    reg        done_d_r;
    wire       match_rise;
    wire       done_rise;

    rlts_sync #(.W(5)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_addr_match, i_pkt_done, i_pkt_has_pay, i_pkt_id}),
        .o_sync     (lnk_s)
    );
    assign lnk_match  = lnk_s[4];
    assign lnk_done   = lnk_s[3];
    assign lnk_pay    = lnk_s[2];
    assign lnk_id     = lnk_s[1:0];
    assign match_rise = lnk_match & ~match_d_r;
    assign done_rise  = lnk_done & ~done_d_r;

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    reg        activate_r;
    reg  [7:0] cfg_r;
    reg  [2:0] status_r;
    reg  [2:0] status_nxt;
    reg  [2:0] mask_r;
    reg  [3:0] retry_limit_r;
    reg  [3:0] retry_delay_r;
    reg  [3:0] retry_count_r;
    reg  [7:0] txlen_r;
    reg        tx_queued_r;
    reg        ack_pay_r;
    reg        ack_pay_sent_r;
    reg  [1:0] tx_id_r;
    reg  [1:0] last_id_r;
    reg        last_valid_r;
    reg  [2:0] state_r;
    reg        act_d_r;
    reg        ack_send_r;
    reg        tmr_load;
    reg [19:0] tmr_count;
    wire       tmr_done;
    wire       act_rise;
    wire       prim_rx;
    wire       no_ack;

    assign prim_rx  = cfg_r[`RLTS_CFG_PRIM_RX];
    assign no_ack   = cfg_r[`RLTS_CFG_NO_ACK];
    assign act_rise = activate_r & ~act_d_r;

    function wr_hit;
        input [3:0] a;
        begin
            wr_hit = i_wr && (i_addr == a);
        end
    endfunction

    rlts_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_load     (tmr_load),
        .i_count    (tmr_count),
        .o_busy     (),
        .o_done     (tmr_done)
    );

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    reg  [2:0] ev;
    reg        ev_drop;

    always @* begin
        ev        = 3'b000;
        tmr_load  = 1'b0;
        tmr_count = 20'h0_0000;
        ev_drop   = 1'b0;
        case (state_r)
            S_IDLE: begin
                // Settling starts on the rising edge of activate
                if (!prim_rx && act_rise && tx_queued_r) begin
                    tmr_load  = 1'b1;
                    tmr_count = `RLTS_SETTLE_CYC;
                end
            end
            S_SETTLE: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = {4'h0, txlen_r, 3'b000} * `RLTS_BIT_CYC;
                end
            end
            S_TX: begin
                if (tmr_done && !no_ack) begin
                    tmr_load  = 1'b1;
                    tmr_count = `RLTS_ACK_WAIT_CYC;
                end else if (tmr_done) begin
                    ev[`RLTS_ST_TX_DATA_SENT_FLAG] = 1'b1;
                end
            end
            S_ACKW: begin
                if (tmr_done && !match_rise && !lnk_match) begin
                    if (retry_count_r >= retry_limit_r) begin
                        ev[`RLTS_ST_RETRY] = 1'b1;
                    end else begin
                        tmr_load  = 1'b1;
                        tmr_count = {15'h0000, {1'b0, retry_delay_r} + 5'h01}
                                    * `RLTS_DELAY_STEP_CYC;
                    end
                end
            end
            S_ACKRX: begin
                if (done_rise) begin
                    ev[`RLTS_ST_TX_DATA_SENT_FLAG] = 1'b1;
                    ev[`RLTS_ST_RX_DATA_READY_FLAG] = lnk_pay;
                end
            end
            S_DELAY: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = `RLTS_SETTLE_CYC;
                end
            end
            S_PRX: begin
                if (done_rise) begin
                    if (last_valid_r && lnk_id == last_id_r) begin
                        ev_drop = 1'b1;
                    end else begin
                        ev[`RLTS_ST_RX_DATA_READY_FLAG] = 1'b1;
                        ev[`RLTS_ST_TX_DATA_SENT_FLAG] = ack_pay_sent_r;
                    end
                    tmr_load  = 1'b1;
                    tmr_count = `RLTS_SETTLE_CYC;
                end
            end
            S_PRXACK: begin
                if (tmr_done && !ack_send_r) begin
                    tmr_load  = 1'b1;
                    tmr_count = 20'h0_0800;
                end
            end
            default: ev = 3'b000;
        endcase
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_r        <= S_IDLE;
            retry_count_r  <= 4'h0;
            last_id_r      <= 2'b00;
            last_valid_r   <= 1'b0;
            ack_pay_sent_r <= 1'b0;
            tx_id_r        <= 2'b00;
            match_d_r      <= 1'b0;
            done_d_r       <= 1'b0;
            act_d_r        <= 1'b0;
            ack_send_r     <= 1'b0;
        end else begin
            match_d_r <= lnk_match;
            done_d_r  <= lnk_done;
            act_d_r   <= activate_r;
            ack_send_r <= (state_r == S_PRXACK) && (ack_send_r ? !tmr_done : tmr_load);
            case (state_r)
                S_IDLE: begin
                    if (prim_rx && activate_r) begin
                        state_r <= S_PRX;
                    end else if (tmr_load) begin
                        retry_count_r <= 4'h0;
                        state_r       <= S_SETTLE;
                    end
                end
                S_SETTLE: if (tmr_done) state_r <= S_TX;
                S_TX: begin
                    if (tmr_done) begin
                        state_r <= no_ack ? S_IDLE : S_ACKW;
                        if (no_ack) tx_id_r <= tx_id_r + 2'b01;
                    end
                end
                S_ACKW: begin
                    if (match_rise || lnk_match) begin
                        state_r <= S_ACKRX;
                    end else if (tmr_done) begin
                        state_r <= tmr_load ? S_DELAY : S_IDLE;
                    end
                end
                S_ACKRX: begin
                    if (done_rise) begin
                        state_r <= S_IDLE;
                        tx_id_r <= tx_id_r + 2'b01;
                    end
                end
                S_DELAY: begin
                    if (tmr_done) begin
                        retry_count_r <= retry_count_r + 4'h1;
                        state_r       <= S_SETTLE;
                    end
                end
                S_PRX: begin
                    if (!activate_r || !prim_rx) begin
                        state_r <= S_IDLE;
                    end else if (done_rise) begin
                        if (!ev_drop) begin
                            last_id_r      <= lnk_id;
                            last_valid_r   <= 1'b1;
                            ack_pay_sent_r <= 1'b0;
                        end
                        state_r <= S_PRXACK;
                    end
                end
                S_PRXACK: begin
                    if (tmr_done && ack_send_r) begin
                        state_r <= S_PRX;
                        if (ack_pay_r) ack_pay_sent_r <= 1'b1;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Register file and sticky flags
    // -------------------------------------------------------------------------
    always @* begin
        // Set wins over a same-cycle clear
        status_nxt = status_r;
        if (wr_hit(`RLTS_ADDR_STATUS)) status_nxt = status_r & ~i_wdata[2:0];
        status_nxt = status_nxt | ev;
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            activate_r    <= 1'b0;
            cfg_r         <= `RLTS_CFG_RST;
            status_r      <= 3'b000;
            mask_r        <= `RLTS_MASK_RST;
            {retry_delay_r, retry_limit_r} <= `RLTS_RETRY_RST;
            txlen_r       <= `RLTS_TXLEN_RST;
            tx_queued_r   <= 1'b0;
            ack_pay_r     <= 1'b0;
            o_rdata       <= 8'h00;
        end else begin
            status_r <= status_nxt;
            if (wr_hit(`RLTS_ADDR_CTRL)) begin
                activate_r <= i_wdata[`RLTS_CTRL_ACTIVATE];
                if (i_wdata[`RLTS_CTRL_LOAD]) tx_queued_r <= 1'b1;
                if (i_wdata[`RLTS_CTRL_ACKLOAD]) ack_pay_r <= 1'b1;
            end
            // Acked packet leaves the queue; retry limit keeps it
            if (ev[`RLTS_ST_TX_DATA_SENT_FLAG] && !prim_rx) tx_queued_r <= 1'b0;
            if (state_r == S_PRXACK && tmr_done && ack_send_r) begin
                ack_pay_r <= 1'b0;
            end
            if (wr_hit(`RLTS_ADDR_CTRL) && i_wdata[`RLTS_CTRL_FLUSH]) begin
                tx_queued_r <= 1'b0;
                ack_pay_r   <= 1'b0;
            end
            if (wr_hit(`RLTS_ADDR_CFG)) cfg_r <= i_wdata;
            if (wr_hit(`RLTS_ADDR_MASK)) mask_r <= i_wdata[2:0];
            if (wr_hit(`RLTS_ADDR_RETRY)) begin
                retry_limit_r <= i_wdata[3:0];
                retry_delay_r <= i_wdata[7:4];
            end
            if (wr_hit(`RLTS_ADDR_TXLEN)) txlen_r <= i_wdata;
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `RLTS_ADDR_CTRL:   o_rdata <= {5'h00, ack_pay_r, tx_queued_r, activate_r};
                    `RLTS_ADDR_CFG:    o_rdata <= cfg_r;
                    `RLTS_ADDR_STATUS: o_rdata <= {5'h00, status_r};
                    `RLTS_ADDR_MASK:   o_rdata <= {5'h00, mask_r};
                    `RLTS_ADDR_RETRY:  o_rdata <= {retry_delay_r, retry_limit_r};
                    `RLTS_ADDR_STATE:  o_rdata <= {1'b0, state_r, retry_count_r};
                    `RLTS_ADDR_TXLEN:  o_rdata <= txlen_r;
                    default:           o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // Air link outputs
    // -------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_tx_on     <= 1'b0;
            o_rx_on     <= 1'b0;
            o_tx_is_ack <= 1'b0;
            o_tx_pkt_id <= 2'b00;
            o_tx_pay_en <= 1'b0;
        end else begin
            o_tx_on     <= ((state_r == S_TX) || ack_send_r) && !tmr_done;
            o_rx_on     <= (state_r == S_ACKW) || (state_r == S_ACKRX) ||
                           (state_r == S_PRX);
            o_tx_is_ack <= (state_r == S_PRXACK);
            o_tx_pkt_id <= tx_id_r;
            o_tx_pay_en <= (state_r == S_PRXACK) && ack_pay_r;
        end
    end

    // Level interrupt, masked bits ignored
    assign o_radio_interrupt = |(status_r & mask_r);
endmodule

//--- rtl/rlts_consts.vh
// Constants for the radio link transaction sequencer
`ifndef RLTS_CONSTS_VH
`define RLTS_CONSTS_VH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define RLTS_ADDR_CTRL      4'h0
`define RLTS_ADDR_CFG       4'h1
`define RLTS_ADDR_STATUS    4'h2
`define RLTS_ADDR_MASK      4'h3
`define RLTS_ADDR_RETRY     4'h4
`define RLTS_ADDR_STATE     4'h5
`define RLTS_ADDR_TXLEN     4'h6

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define RLTS_CTRL_ACTIVATE  0
`define RLTS_CTRL_FLUSH     1
`define RLTS_CTRL_LOAD      2
`define RLTS_CTRL_ACKLOAD   3
`define RLTS_CFG_PRIM_RX    0
`define RLTS_CFG_NO_ACK     1
`define RLTS_ST_RX_DATA_READY_FLAG       0
`define RLTS_ST_TX_DATA_SENT_FLAG       1
`define RLTS_ST_RETRY       2

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define RLTS_CFG_RST        8'h00
`define RLTS_MASK_RST       3'h7
`define RLTS_RETRY_RST      8'h03
`define RLTS_TXLEN_RST      8'h20

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define RLTS_CLK_MHZ        50
`define RLTS_SETTLE_US      130
`define RLTS_SETTLE_CYC     20'h0_1964
`define RLTS_ACK_WAIT_US    250
`define RLTS_ACK_WAIT_CYC   20'h0_30D4
`define RLTS_DELAY_STEP_US  250
`define RLTS_DELAY_STEP_CYC 20'h0_30D4
`define RLTS_BIT_CYC        20'h0_0032

`endif

//--- rtl/rlts_timer.v
// Down counter timer with load and expiry pulse
`timescale 1ns/100ps
module rlts_timer (
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    // Control
    input  wire        i_load,
    input  wire [19:0] i_count,
    // Status
    output wire        o_busy,
    output wire        o_done
);
    reg [19:0] cnt_r;
    reg        done_r;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= 20'h0_0000;
            done_r <= 1'b0;
        end else if (i_load) begin
            cnt_r  <= i_count;
            done_r <= 1'b0;
        end else begin
            done_r <= (cnt_r == 20'h0_0001);
            if (cnt_r != 20'h0_0000) begin
                cnt_r <= cnt_r - 20'h0_0001;
            end
        end
    end

    assign o_busy = (cnt_r != 20'h0_0000);
    assign o_done = done_r;
endmodule

//--- rtl/rlts_sync.v
// Two flip-flop synchroniser for the link inputs
`timescale 1ns/100ps
module rlts_sync #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         i_core_clk,
    input  wire         i_rst_n,
    // Data
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
        end
    end

    assign o_sync = s2_r;
endmodule

//--- bench/rlts_checker.sv
// Port checker for the radio link sequencer
`timescale 1ns/100ps
`include "rlts_consts.vh"
module rlts_checker (
    // Clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Air link
    input wire logic       i_addr_match,
    input wire logic       i_pkt_done,
    input wire logic       i_pkt_has_pay,
    input wire logic [1:0] i_pkt_id,
    input wire logic       o_tx_on,
    input wire logic       o_rx_on,
    input wire logic       o_tx_is_ack,
    input wire logic [1:0] o_tx_pkt_id,
    input wire logic       o_tx_pay_en,
    // Interrupt
    input wire logic       o_radio_interrupt
);
    // ------
    // Shadow config and run lengths
    // ------
    logic        prim_r;
    logic        noack_r;
    logic [2:0]  mask_r;
    logic [7:0]  len_r;
    logic [19:0] on_r;
    logic [19:0] rx_r;
    logic [19:0] idle_r;
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            prim_r  <= 1'b0;
            noack_r <= 1'b0;
            mask_r  <= `RLTS_MASK_RST;
            len_r   <= `RLTS_TXLEN_RST;
            on_r    <= 20'h0_0000;
            rx_r    <= 20'h0_0000;
            idle_r  <= 20'h0_0000;
        end else begin
            if (i_wr && i_addr == `RLTS_ADDR_CFG) begin
                prim_r  <= i_wdata[0];
                noack_r <= i_wdata[1];
            end
            if (i_wr && i_addr == `RLTS_ADDR_MASK) begin
                mask_r <= i_wdata[2:0];
            end
            if (i_wr && i_addr == `RLTS_ADDR_TXLEN) begin
                len_r <= i_wdata;
            end
            on_r <= o_tx_on ? on_r + 20'h0_0001 : 20'h0_0000;
            rx_r <= o_rx_on ? rx_r + 20'h0_0001 : 20'h0_0000;
            // Saturates so a long idle never wraps
            idle_r <= (o_tx_on || o_rx_on) ? 20'h0_0000 : idle_r + {19'h0_0000, ~&idle_r};
        end
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ------
    // Properties
    // ------
    property p_no_overlap;
        !(o_tx_on && o_rx_on);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("tx and rx on together");
    property p_settle;
        $rose(o_tx_on) && !o_tx_is_ack |-> idle_r >= `RLTS_SETTLE_CYC - 4;
    endproperty
    a_settle: assert property (p_settle) else $error("send before settling");
    property p_on_air;
        $fell(o_tx_on) |-> on_r == ($past(o_tx_is_ack) ? 20'h0_0800 : len_r * 20'h0_0190);
    endproperty
    a_on_air: assert property (p_on_air) else $error("wrong on-air length");
    property p_turn_rx;
        $fell(o_tx_on) && !noack_r |-> ##[0:2] o_rx_on;
    endproperty
    a_turn_rx: assert property (p_turn_rx) else $error("no receive after send");
    property p_ack_slot;
        o_rx_on && !prim_r && !i_addr_match |-> rx_r <= `RLTS_ACK_WAIT_CYC + 4;
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack wait too long");
    property p_addr_hold;
        o_rx_on && !prim_r && i_addr_match && !i_pkt_done |=> o_rx_on;
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("receive cut short");
    property p_done_irq;
        $rose(i_pkt_done) && o_rx_on && !prim_r && mask_r[2:0] == 3'h7
            |-> ##[2:6] o_radio_interrupt;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("no interrupt on ack");
    property p_prx_ack;
        $rose(i_pkt_done) && o_rx_on && prim_r |-> ##[1:8] o_tx_is_ack;
    endproperty
    a_prx_ack: assert property (p_prx_ack) else $error("no ack turn-round");
    property p_sticky;
        o_radio_interrupt && !(i_wr && (i_addr == `RLTS_ADDR_STATUS
            || i_addr == `RLTS_ADDR_MASK)) |=> o_radio_interrupt;
    endproperty
    a_sticky: assert property (p_sticky) else $error("interrupt dropped");
    c_ack_rx: cover property ($rose(i_pkt_done) && o_rx_on && !prim_r);
    c_retry: cover property ($rose(o_tx_on) && idle_r > `RLTS_ACK_WAIT_CYC);
    c_ack_tx: cover property ($rose(o_tx_is_ack));
endmodule
bind rlts_sequencer rlts_checker u_rlts_checker (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_addr_match(i_addr_match),
    .i_pkt_done(i_pkt_done), .i_pkt_has_pay(i_pkt_has_pay), .i_pkt_id(i_pkt_id),
    .o_tx_on(o_tx_on), .o_rx_on(o_rx_on), .o_tx_is_ack(o_tx_is_ack),
    .o_tx_pkt_id(o_tx_pkt_id), .o_tx_pay_en(o_tx_pay_en),
    .o_radio_interrupt(o_radio_interrupt)
);

//--- bench/rlts_peer_model.sv
// Peer radio model answering the sequencer over the air
`timescale 1ns/100ps
module rlts_peer_model (
    // Clock
    input  wire logic i_core_clk,
    // Link indications
    output logic       o_addr_match,
    output logic       o_pkt_done,
    output logic       o_pkt_has_pay,
    output logic [1:0] o_pkt_id
);
    initial begin
        o_addr_match = 1'b0;
        o_pkt_done = 1'b0;
        o_pkt_has_pay = 1'b0;
        o_pkt_id = 2'h0;
    end
    // ------
    // One packet: lag, address, completion held past the synchroniser
    // ------
    task automatic send_pkt(input logic [1:0] id, input logic pay, input int lag);
        repeat (lag) @(posedge i_core_clk);
        o_addr_match <= 1'b1;
        repeat (16) @(posedge i_core_clk);
        o_pkt_done <= 1'b1;
        o_pkt_has_pay <= pay;
        o_pkt_id <= id;
        repeat (4) @(posedge i_core_clk);
        o_addr_match <= 1'b0;
        o_pkt_done <= 1'b0;
        // Released lines driven to the inverse: never leave a stale copy
        o_pkt_has_pay <= ~pay;
        o_pkt_id <= ~id;
    endtask
endmodule

//--- bench/test_radio_link_transaction_sequencer.sv
// Self-checking bench for the radio link sequencer
`timescale 1ns/100ps
`include "rlts_consts.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
$display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_radio_link_transaction_sequencer;
    logic       i_core_clk;
    logic       i_rst_n;
    logic       i_wr;
    logic       i_rd;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    wire  [7:0] o_rdata;
    wire        mtch;
    wire        done;
    wire        pay;
    wire  [1:0] packet_identifier;
    wire        o_tx_on;
    wire        o_rx_on;
    wire        o_tx_is_ack;
    wire  [1:0] o_tx_pkt_id;
    wire        o_tx_pay_en;
    wire        o_radio_interrupt;
    int         n_mismatch = 0;
    int         comparisons = 0;
    rlts_sequencer DUT (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_addr_match(mtch),
        .i_pkt_done(done), .i_pkt_has_pay(pay), .i_pkt_id(packet_identifier),
        .o_tx_on(o_tx_on), .o_rx_on(o_rx_on), .o_tx_is_ack(o_tx_is_ack),
        .o_tx_pkt_id(o_tx_pkt_id), .o_tx_pay_en(o_tx_pay_en),
        .o_radio_interrupt(o_radio_interrupt)
    );
    rlts_peer_model PEER (
        .i_core_clk(i_core_clk), .o_addr_match(mtch), .o_pkt_done(done),
        .o_pkt_has_pay(pay), .o_pkt_id(packet_identifier)
    );
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    // ------
    // Bus and wait helpers
    // ------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(nm, e, o_rdata)
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return o_tx_on;
            1: return o_rx_on;
            2: return o_tx_is_ack;
            default: return o_radio_interrupt;
        endcase
    endfunction
    // Bounded wait on one output
    task automatic wait_on(input int s, input logic lvl, input int lim, output int n);
        n = 0;
        @(posedge i_core_clk);
        #1;
        while (pick(s) !== lvl && n < lim) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        `CHK("wait", lvl, pick(s))
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_reset;
        `CHK("irq", 1'b0, o_radio_interrupt)
        rd(`RLTS_ADDR_MASK, `RLTS_MASK_RST, "mask");
        rd(`RLTS_ADDR_RETRY, `RLTS_RETRY_RST, "retry");
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
    endtask
    task automatic t_ptx_ack;
        int n;
        wr(`RLTS_ADDR_TXLEN, 8'h01);
        wr(`RLTS_ADDR_RETRY, 8'h01);
        wr(`RLTS_ADDR_CTRL, 8'h04);
        wr(`RLTS_ADDR_CTRL, 8'h05);
        wait_on(0, 1'b1, 6600, n);
        `CHK("settle", 1'b1, n >= 6490)
        wait_on(1, 1'b1, 420, n);
        `CHK("air", 1'b1, n >= 395)
        rd(`RLTS_ADDR_STATUS, 8'h00, "status");
        PEER.send_pkt(2'h1, 1'b1, 30);
        wait_on(3, 1'b1, 8, n);
        rd(`RLTS_ADDR_STATUS, 8'h03, "status");
        rd(`RLTS_ADDR_CTRL, 8'h01, "ctrl");
        wr(`RLTS_ADDR_STATUS, 8'h03);
        rd(`RLTS_ADDR_STATUS, 8'h00, "status");
        `CHK("irq", 1'b0, o_radio_interrupt)
        wr(`RLTS_ADDR_CTRL, 8'h00);
        repeat (`RLTS_SETTLE_CYC) @(posedge i_core_clk);
    endtask
    task automatic t_ptx_retry;
        int n;
        logic [1:0] id0;
        wr(`RLTS_ADDR_CTRL, 8'h04);
        wr(`RLTS_ADDR_CTRL, 8'h05);
        wait_on(0, 1'b1, 6600, n);
        id0 = o_tx_pkt_id;
        wait_on(1, 1'b1, 420, n);
        wait_on(1, 1'b0, 12520, n);
        `CHK("slot", 1'b1, n >= 12480)
        wait_on(0, 1'b1, 19100, n);
        `CHK("delay", 1'b1, n >= 18990)
        `CHK("same id", id0, o_tx_pkt_id)
        wait_on(1, 1'b1, 420, n);
        wait_on(1, 1'b0, 12950, n);
        wait_on(3, 1'b1, 8, n);
        rd(`RLTS_ADDR_STATUS, 8'h04, "status");
        rd(`RLTS_ADDR_CTRL, 8'h03, "ctrl");
        wr(`RLTS_ADDR_MASK, 8'h03);
        rd(`RLTS_ADDR_STATUS, 8'h04, "status");
        `CHK("masked", 1'b0, o_radio_interrupt)
        wr(`RLTS_ADDR_MASK, 8'h07);
        wr(`RLTS_ADDR_STATUS, 8'h04);
        rd(`RLTS_ADDR_STATUS, 8'h00, "status");
        wr(`RLTS_ADDR_CTRL, 8'h02);
        rd(`RLTS_ADDR_CTRL, 8'h00, "ctrl");
    endtask
    task automatic t_ptx_noack;
        int n;
        repeat (`RLTS_SETTLE_CYC) @(posedge i_core_clk);
        wr(`RLTS_ADDR_CFG, 8'h02);
        wr(`RLTS_ADDR_CTRL, 8'h04);
        wr(`RLTS_ADDR_CTRL, 8'h05);
        wait_on(0, 1'b1, 6600, n);
        wait_on(3, 1'b1, 420, n);
        rd(`RLTS_ADDR_STATUS, 8'h02, "status");
        wr(`RLTS_ADDR_STATUS, 8'h02);
        wr(`RLTS_ADDR_CTRL, 8'h00);
    endtask
    task automatic ack_cycle(input logic p);
        int n;
        wait_on(0, 1'b1, 6600, n);
        `CHK("ack mode", 1'b1, o_tx_is_ack)
        `CHK("ack pay", p, o_tx_pay_en)
        wait_on(0, 1'b0, 2100, n);
        `CHK("ack len", 1'b1, n >= 2040)
        wait_on(1, 1'b1, 4, n);
    endtask
    task automatic t_prx;
        int n;
        wr(`RLTS_ADDR_CFG, 8'h01);
        wr(`RLTS_ADDR_CTRL, 8'h01);
        wait_on(1, 1'b1, 6600, n);
        PEER.send_pkt(2'h1, 1'b0, 40);
        wait_on(3, 1'b1, 8, n);
        rd(`RLTS_ADDR_STATUS, 8'h01, "status");
        wr(`RLTS_ADDR_STATUS, 8'h01);
        ack_cycle(1'b0);
        wr(`RLTS_ADDR_CTRL, 8'h09);
        PEER.send_pkt(2'h1, 1'b0, 40);
        wait_on(2, 1'b1, 8, n);
        ack_cycle(1'b1);
        rd(`RLTS_ADDR_STATUS, 8'h00, "status");
        PEER.send_pkt(2'h2, 1'b0, 40);
        wait_on(3, 1'b1, 8, n);
        rd(`RLTS_ADDR_STATUS, 8'h03, "status");
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_ptx_ack();
        t_ptx_retry();
        t_ptx_noack();
        t_prx();
        wrap_up();
    end
    // Run needs about 96k cycles
    initial begin
        repeat (105000) @(posedge i_core_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
